//--- serial_baud_break_defs.svh
`ifndef SERIAL_BAUD_BREAK_DEFS_SVH
`define SERIAL_BAUD_BREAK_DEFS_SVH

// Register offsets on the plain register port.
`define SBB_ADDR_W        4
`define SBB_CFG_ADDR      4'h0
`define SBB_STAT_ADDR     4'h4
`define SBB_ERR0_ADDR     4'h8
`define SBB_ERR1_ADDR     4'hc
`define SBB_DATA_W        16

// Configuration field positions and reset value.
`define SBB_CFG_RATE0_LSB 0
`define SBB_CFG_EXT0_BIT  3
`define SBB_CFG_RATE1_LSB 4
`define SBB_CFG_EXT1_BIT  7
`define SBB_CFG_BRK_LSB   8
`define SBB_CFG_TICK_BIT  10
`define SBB_CFG_RESET     16'h0257

// Error word field positions.
`define SBB_ERR_ANY_BIT   15
`define SBB_ERR_FE_BIT    13

// Clock and rate figures.
`define SBB_CLK_HZ        250000000
`define SBB_TICK_HZ       60
`define SBB_OVERSAMPLE    16
`define SBB_BREAK_BITS    11
`define SBB_BAUD_0        150
`define SBB_BAUD_1        300
`define SBB_BAUD_2        1200
`define SBB_BAUD_3        2400
`define SBB_BAUD_4        4800
`define SBB_BAUD_5        9600
`define SBB_BAUD_6        19200
`define SBB_BAUD_7        38400

// Derived counts.
`define SBB_BREAK_TICKS   (`SBB_OVERSAMPLE * `SBB_BREAK_BITS)
`define SBB_TICK_HALF     (`SBB_CLK_HZ / (2 * `SBB_TICK_HZ))

`endif

//--- serial_baud_break_pkg.sv
package serial_baud_break_pkg;

    typedef enum logic [1:0] {
        BRK_NONE   = 2'b00,
        BRK_REBOOT = 2'b01,
        BRK_HALT   = 2'b10
    } brk_resp_t;

    typedef enum logic [1:0] {
        RX_MARK  = 2'b00,
        RX_SPACE = 2'b01,
        RX_BREAK = 2'b10
    } rx_state_t;

endpackage : serial_baud_break_pkg

//--- serial_baud_break_clock.sv
// What this block does
// - Each line's transmitter and receiver share one bit-rate enable.
// - Each line can run from an internal rate between 150 and 38400 baud.
// - The generator offers 150, 300, 1200, 2400, 4800, 9600, 19200, 38400.
// - Each line takes exactly one clock, an internal rate or external.
// - The connector clock pin drives out when internal, is input else.
// - A continuous spacing level on receive data is a framing error.
// - Only the console line answers a break: reboot, halt or nothing.
// - After reset the console break answer is a halt request.
// - A 60 Hz tick is derived from the clock and may drive the event line.
// - The tick stays off the event line until configuration enables it.
// - Terminal ready and request to send are held asserted.
// - There is no reader-run control output.
// - Receive errors, break included, read in data bits 15 and 13.
`timescale 1ns/1ps
`include "serial_baud_break_defs.svh"

module serial_baud_break_clock #(
    parameter int TICK_HALF = `SBB_TICK_HALF
) (
    input  wire logic                      I_CLK,
    input  wire logic                      I_ARST_N,
    input  wire logic [`SBB_ADDR_W-1:0]    I_ADDR,
    input  wire logic [`SBB_DATA_W-1:0]    I_WDATA,
    input  wire logic                      I_WR,
    input  wire logic                      I_RD,
    output logic      [`SBB_DATA_W-1:0]    O_RDATA,
    input  wire logic [1:0]                I_RXD,
    input  wire logic [1:0]                I_CLKPIN,
    output logic      [1:0]                O_CLKPIN,
    output logic      [1:0]                O_CLKPIN_OE_N,
    output logic      [1:0]                O_BAUD16_EN,
    output logic                           O_REBOOT_REQ,
    output logic                           O_HALT_REQ,
    input  wire logic                      I_EVENT,
    output logic                           O_EVENT,
    output logic                           O_EVENT_OE_N,
    output logic      [1:0]                O_DTR_N,
    output logic      [1:0]                O_RTS_N
);

    // Wide enough for the half period of the slowest rate at this clock.
    localparam int DIV_W = 17;

    // Half period of the 16x clock for a rate code, never below one cycle.
    function automatic logic [DIV_W-1:0] half_div(input logic [2:0] code);
        int baud;
        int div;
        baud = `SBB_BAUD_0;
        case (code)
            3'h0: baud = `SBB_BAUD_0;
            3'h1: baud = `SBB_BAUD_1;
            3'h2: baud = `SBB_BAUD_2;
            3'h3: baud = `SBB_BAUD_3;
            3'h4: baud = `SBB_BAUD_4;
            3'h5: baud = `SBB_BAUD_5;
            3'h6: baud = `SBB_BAUD_6;
            3'h7: baud = `SBB_BAUD_7;
            default: baud = `SBB_BAUD_0;
        endcase
        div = `SBB_CLK_HZ / (2 * `SBB_OVERSAMPLE * baud);
        // A rate too fast for the clock would give zero and stall the line.
        if (div < 1) begin
            div = 1;
        end
        return div[DIV_W-1:0];
    endfunction : half_div

    logic [`SBB_DATA_W-1:0] cfg_q;
    logic [1:0]             fe_q;
    logic [1:0]             brk_q;
    logic [1:0]             brk_rise;
    logic [1:0]             ev_s;
    logic                   tick_phase_q;
    logic [31:0]            tick_cnt_q;
    logic                   wr_cfg;
    logic [1:0]             rd_err;
    serial_baud_break_pkg::brk_resp_t brk_resp;

    // Strobe decode; writes anywhere but the configuration word are lost.
    assign wr_cfg    = I_WR && (I_ADDR == `SBB_CFG_ADDR);
    assign rd_err[0] = I_RD && (I_ADDR == `SBB_ERR0_ADDR);
    assign rd_err[1] = I_RD && (I_ADDR == `SBB_ERR1_ADDR);
    assign brk_resp  = serial_baud_break_pkg::brk_resp_t'(
                           cfg_q[`SBB_CFG_BRK_LSB +: 2]);

    // Configuration word; the reset value selects the halt answer.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cfg_q <= `SBB_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= I_WDATA;
        end
    end

    // Per-line clock selection, pin handling and break detection.
    for (genvar g = 0; g < 2; g++) begin : g_line
        logic [2:0]       rate;
        logic             ext;
        logic [DIV_W-1:0] div_cnt_q;
        logic             pin_q;
        logic [2:0]       pin_s;
        logic [1:0]       rx_s;
        logic             int_edge;
        logic             ext_edge;
        logic             en16;
        logic [7:0]       sp_cnt_q;
        serial_baud_break_pkg::rx_state_t st_q;

        assign rate = (g == 0) ? cfg_q[`SBB_CFG_RATE0_LSB +: 3]
                               : cfg_q[`SBB_CFG_RATE1_LSB +: 3];
        assign ext  = (g == 0) ? cfg_q[`SBB_CFG_EXT0_BIT]
                               : cfg_q[`SBB_CFG_EXT1_BIT];

        // Internal divider; a rising half marks one 16x enable.
        always_ff @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                div_cnt_q <= '0;
                pin_q     <= 1'b0;
            end else if (div_cnt_q >= half_div(rate) - 1'b1) begin
                div_cnt_q <= '0;
                pin_q     <= ~pin_q;
            end else begin
                div_cnt_q <= div_cnt_q + 1'b1;
            end
        end

        // The wrap that raises the pin is the one that gives the enable.
        assign int_edge = (div_cnt_q >= half_div(rate) - 1'b1) && !pin_q;

        // The pin is a foreign clock, so it passes two flops first.
        always_ff @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                pin_s <= '0;
                rx_s  <= 2'b11;
            end else begin
                pin_s <= {pin_s[1:0], I_CLKPIN[g]};
                rx_s  <= {rx_s[0], I_RXD[g]};
            end
        end

        assign ext_edge = pin_s[1] && !pin_s[2];
        // One static choice feeds both directions of the line.
        assign en16     = ext ? ext_edge : int_edge;

        // Pin drives our clock when internal, released when external.
        always_ff @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                O_CLKPIN[g]      <= 1'b0;
                O_CLKPIN_OE_N[g] <= 1'b1;
                O_BAUD16_EN[g]   <= 1'b0;
            end else begin
                O_CLKPIN[g]      <= pin_q;
                O_CLKPIN_OE_N[g] <= ext;
                O_BAUD16_EN[g]   <= en16;
            end
        end

        // Spacing held for a whole frame at the line rate is a break.
        // Counting on the 16x enable keeps the threshold rate-relative.
        always_ff @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                st_q     <= serial_baud_break_pkg::RX_MARK;
                sp_cnt_q <= '0;
            end else if (rx_s[1]) begin
                st_q     <= serial_baud_break_pkg::RX_MARK;
                sp_cnt_q <= '0;
            end else if (en16) begin
                case (st_q)
                    serial_baud_break_pkg::RX_MARK: begin
                        st_q     <= serial_baud_break_pkg::RX_SPACE;
                        sp_cnt_q <= 8'h01;
                    end
                    serial_baud_break_pkg::RX_SPACE: begin
                        if (sp_cnt_q >= 8'(`SBB_BREAK_TICKS - 1)) begin
                            st_q <= serial_baud_break_pkg::RX_BREAK;
                        end
                        sp_cnt_q <= sp_cnt_q + 1'b1;
                    end
                    serial_baud_break_pkg::RX_BREAK: begin
                        st_q <= serial_baud_break_pkg::RX_BREAK;
                    end
                    default: begin
                        st_q <= serial_baud_break_pkg::RX_MARK;
                    end
                endcase
            end
        end

        // Break state as a flag for status and for the request edge.
        assign brk_q[g] = (st_q == serial_baud_break_pkg::RX_BREAK);

        // Framing flag: set on break entry, cleared by reading its word.
        // A set in the same cycle as the read wins, so no break is lost.
        always_ff @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                fe_q[g] <= 1'b0;
            end else if (brk_rise[g]) begin
                fe_q[g] <= 1'b1;
            end else if (rd_err[g]) begin
                fe_q[g] <= 1'b0;
            end
        end
    end

    // Edge of the break state gives one event per break.
    logic [1:0] brk_d1_q;

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            brk_d1_q <= '0;
        end else begin
            brk_d1_q <= brk_q;
        end
    end

    // Only the rising edge counts, so a long break cannot repeat a request.
    assign brk_rise = brk_q & ~brk_d1_q;

    // Console-only break answer, one pulse per event.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_REBOOT_REQ <= 1'b0;
            O_HALT_REQ   <= 1'b0;
        end else begin
            O_REBOOT_REQ <= brk_rise[1] &&
                (brk_resp == serial_baud_break_pkg::BRK_REBOOT);
            O_HALT_REQ   <= brk_rise[1] &&
                (brk_resp == serial_baud_break_pkg::BRK_HALT);
        end
    end

    // The 60 Hz square wave runs free whether or not it is connected.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            tick_cnt_q   <= '0;
            tick_phase_q <= 1'b0;
        end else if (tick_cnt_q >= 32'(TICK_HALF - 1)) begin
            tick_cnt_q   <= '0;
            tick_phase_q <= ~tick_phase_q;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    // Open-drain drive: the line is only ever pulled low, never driven
    // high, so a board holding it at ground always overrides the tick.
    // The line level reads back in status bit 4, so another board's pull is visible.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_EVENT      <= 1'b0;
            O_EVENT_OE_N <= 1'b1;
        end else begin
            O_EVENT      <= 1'b0;
            O_EVENT_OE_N <= !(cfg_q[`SBB_CFG_TICK_BIT] &&
                              tick_phase_q);
        end
    end

    // Event line level for status, through two flops.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ev_s <= 2'b11;
        end else begin
            ev_s <= {ev_s[0], I_EVENT};
        end
    end

    // Modem controls are strapped asserted; no reader-run pin exists.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_DTR_N <= 2'b00;
            O_RTS_N <= 2'b00;
        end else begin
            O_DTR_N <= 2'b00;
            O_RTS_N <= 2'b00;
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RDATA <= '0;
        end else if (I_RD) begin
            case (I_ADDR)
                `SBB_CFG_ADDR:  O_RDATA <= cfg_q;
                `SBB_STAT_ADDR: O_RDATA <= {11'h000, ev_s[1],
                                            tick_phase_q, fe_q[1],
                                            brk_q};
                `SBB_ERR0_ADDR: O_RDATA <= {fe_q[0], 1'b0, fe_q[0],
                                            13'h0000};
                `SBB_ERR1_ADDR: O_RDATA <= {fe_q[1], 1'b0, fe_q[1],
                                            13'h0000};
                default:        O_RDATA <= '0;
            endcase
        end else begin
            O_RDATA <= '0;
        end
    end

endmodule : serial_baud_break_clock

//--- serial_baud_break_clock_props.sv
`timescale 1ns/1ps
`include "serial_baud_break_defs.svh"
module serial_baud_break_clock_props #(
    parameter int TICK_HALF = `SBB_TICK_HALF
) (
    input wire logic        I_CLK,
    input wire logic        I_ARST_N,
    input wire logic [1:0]  I_RXD,
    input wire logic [1:0]  I_CLKPIN,
    input wire logic [1:0]  O_CLKPIN,
    input wire logic [1:0]  O_CLKPIN_OE_N,
    input wire logic [1:0]  O_BAUD16_EN,
    input wire logic        O_REBOOT_REQ,
    input wire logic        O_HALT_REQ,
    input wire logic        O_EVENT,
    input wire logic        O_EVENT_OE_N,
    input wire logic [1:0]  O_DTR_N,
    input wire logic [1:0]  O_RTS_N
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    // Length of the current pull-low stretch on the event line.
    int lo_q;
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) lo_q <= 0;
        else lo_q <= O_EVENT_OE_N ? 0 : lo_q + 1;
    end

    property p_strap;
        O_DTR_N == 2'b00 && O_RTS_N == 2'b00;
    endproperty
    a_strap: assert property (p_strap)
        else $error("modem control outputs not held asserted");
    property p_drive_low;
        O_EVENT == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("event line driven high");
    property p_tick_len;
        lo_q <= TICK_HALF;
    endproperty
    a_tick_len: assert property (p_tick_len)
        else $error("event pull-low stretch too long");
    property p_ext_edge;
        O_CLKPIN_OE_N[1] && $rose(I_CLKPIN[1]) |-> ##[3:5] O_BAUD16_EN[1];
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("external clock edge gave no rate enable");
    property p_int_pin;
        // The pin flop lags the enable by one cycle, so the enable leads.
        !O_CLKPIN_OE_N[0] && $rose(O_CLKPIN[0]) |-> $past(O_BAUD16_EN[0]);
    endproperty
    a_int_pin: assert property (p_int_pin)
        else $error("pin rise without rate enable");
    property p_excl;
        !(O_HALT_REQ && O_REBOOT_REQ);
    endproperty
    a_excl: assert property (p_excl)
        else $error("halt and reboot requested together");
    property p_once;
        O_HALT_REQ || O_REBOOT_REQ |=> !(O_HALT_REQ || O_REBOOT_REQ) [*8];
    endproperty
    a_once: assert property (p_once)
        else $error("break request repeated");
    property p_space;
        O_HALT_REQ || O_REBOOT_REQ |-> !$past(I_RXD[1], 8);
    endproperty
    a_space: assert property (p_space)
        else $error("break request without spacing line");
endmodule : serial_baud_break_clock_props

bind serial_baud_break_clock serial_baud_break_clock_props #(
    .TICK_HALF(TICK_HALF)
) serial_baud_break_clock_props_inst (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_RXD(I_RXD),
    .I_CLKPIN(I_CLKPIN), .O_CLKPIN(O_CLKPIN),
    .O_CLKPIN_OE_N(O_CLKPIN_OE_N), .O_BAUD16_EN(O_BAUD16_EN),
    .O_REBOOT_REQ(O_REBOOT_REQ), .O_HALT_REQ(O_HALT_REQ),
    .O_EVENT(O_EVENT), .O_EVENT_OE_N(O_EVENT_OE_N),
    .O_DTR_N(O_DTR_N), .O_RTS_N(O_RTS_N)
);

//--- serial_far_end.sv
`timescale 1ns/1ps
module serial_far_end (
    input  wire logic       i_run,
    input  wire logic [1:0] i_brk,
    input  wire logic       i_hold,
    output logic      [1:0] o_rxd,
    output logic            o_clk,
    output logic            o_evt_low
);
    // Idle lines rest at mark; a break is a solid space.
    assign o_rxd = ~i_brk;
    // Another board can only pull the event line low.
    // It never sources a tick, so the block's tick is the only one.
    assign o_evt_low = i_hold;
    // The option clock stands still when unused; its phase is offset so
    // its edges never meet the system clock edges.
    initial begin
        o_clk = 1'b0;
        #1.3;
        forever begin
            #80 o_clk = i_run ? ~o_clk : 1'b0;
        end
    end
endmodule : serial_far_end

//--- serial_baud_break_clock_bench.sv
`timescale 1ns/1ps
module serial_baud_break_clock_bench;
    localparam int TH = 50;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wstb = 1'b0;
    logic        rstb = 1'b0;
    logic [1:0]  brk = 2'b00;
    logic        run = 1'b0;
    logic        hold = 1'b0;
    logic [15:0] rdata;
    logic [1:0]  rxd, pin, oe_n, b16, dtr_n, rts_n, cpin;
    logic        rbt, hlt, ev_o, ev_oe_n, evt, ev_low, xclk;
    logic [1:0]  cd [4] = '{2'd2, 2'd1, 2'd0, 2'd3};
    int          bd [8] = '{150, 300, 1200, 2400, 4800, 9600, 19200, 38400};
    int          n_errors = 0;
    int          n_compared = 0;
    int          halts = 0;
    int          reboots = 0;
    int          n, h, b;

    always #2 clk = ~clk;
    // Each clock pin carries the block's drive or else the option clock.
    assign cpin[0] = oe_n[0] ? xclk : pin[0];
    assign cpin[1] = oe_n[1] ? xclk : pin[1];
    // Open-drain event line with its pull-up.
    assign evt = !(!ev_oe_n || ev_low);

    serial_baud_break_clock #(.TICK_HALF(TH)) serial_baud_break_clock_inst (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wstb), .I_RD(rstb), .O_RDATA(rdata), .I_RXD(rxd),
        .I_CLKPIN(cpin), .O_CLKPIN(pin), .O_CLKPIN_OE_N(oe_n),
        .O_BAUD16_EN(b16), .O_REBOOT_REQ(rbt), .O_HALT_REQ(hlt),
        .I_EVENT(evt), .O_EVENT(ev_o), .O_EVENT_OE_N(ev_oe_n),
        .O_DTR_N(dtr_n), .O_RTS_N(rts_n)
    );
    serial_far_end serial_far_end_inst (
        .i_run(run), .i_brk(brk), .i_hold(hold),
        .o_rxd(rxd), .o_clk(xclk), .o_evt_low(ev_low)
    );

    // Request pulses are tallied so repeats would show up.
    always @(posedge clk) begin
        if (hlt === 1'b1) halts++;
        if (rbt === 1'b1) reboots++;
    end

    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask : put
    // Read data stand only in the cycle after the strobe.
    task automatic rc(input logic [3:0] a, input logic [15:0] m, e);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1 chk(rdata & m, e);
    endtask : rc
    // Cycles up to the next line 0 rate enable, bounded.
    task automatic gap;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (b16[0] !== 1'b1 && n < 20000);
    endtask : gap
    // Cycles for which the event drive enable keeps level v, bounded.
    task automatic span(input logic v);
        n = 0;
        while (ev_oe_n === v && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask : span
    task automatic conclude;
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        // The tests need about 71,000 cycles; this leaves a margin.
        repeat (90000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rc(4'h0, 16'hffff, 16'h0257);
        chk({14'h0, oe_n}, 16'h0000);
        chk({12'h0, dtr_n, rts_n}, 16'h0000);
        put(4'h2, 16'hffff);
        rc(4'h2, 16'hffff, 16'h0000);
        rc(4'h0, 16'hffff, 16'h0257);
        // The first gap after a rate change may be short, so skip two.
        for (int r = 3; r < 8; r++) begin
            put(4'h0, 16'h0250 | 16'(r));
            gap();
            gap();
            gap();
            chk(16'(n), 16'(2 * (250000000 / (32 * bd[r]))));
        end
        run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            put(4'h0, 16'h0088 | {6'h0, cd[i], 8'h0});
            h = halts;
            b = reboots;
            brk <= 2'b11;
            repeat (8000) @(posedge clk);
            chk(16'(halts - h), 16'(cd[i] == 2'd2));
            chk(16'(reboots - b), 16'(cd[i] == 2'd1));
            rc(4'h4, 16'h0007, 16'h0007);
            rc(4'h8, 16'hffff, 16'ha000);
            rc(4'hc, 16'hffff, 16'ha000);
            chk({14'h0, oe_n}, 16'h0003);
            brk <= 2'b00;
            repeat (200) @(posedge clk);
            rc(4'h4, 16'h0003, 16'h0000);
            rc(4'hc, 16'hffff, 16'h0000);
        end
        chk({15'h0, ev_oe_n}, 16'h0001);
        put(4'h0, 16'h0488);
        span(1'b1);
        span(1'b0);
        chk(16'(n), 16'(TH));
        span(1'b1);
        chk(16'(n), 16'(TH));
        put(4'h0, 16'h0088);
        repeat (4) @(posedge clk);
        chk({15'h0, ev_oe_n}, 16'h0001);
        // With the tick off, only the other board can pull the line low.
        hold <= 1'b1;
        repeat (4) @(posedge clk);
        rc(4'h4, 16'h0010, 16'h0000);
        hold <= 1'b0;
        repeat (4) @(posedge clk);
        rc(4'h4, 16'h0010, 16'h0010);
        conclude();
    end
endmodule : serial_baud_break_clock_bench
